// ### rtl/psmrs_addr_map.sv
`default_nettype none
module psmrs_addr_map (
   input  wire logic [20:0] addr,
   input  wire logic [1:0]  memory_mode_select,
   input  wire logic        flash_64k,
   output logic             int_sel,
   output logic             ext_sel,
   output logic             zero_fill
);
   logic [20:0] flash_top;
   logic        in_flash;
   logic        in_boot;

   assign flash_top = flash_64k ? psmrs_pkg::FLASH_TOP_64K : psmrs_pkg::FLASH_TOP_48K;
   assign in_flash  = addr <= flash_top;
   assign in_boot   = addr <= psmrs_pkg::BOOT_TOP;

   always_comb
   begin
      int_sel   = 1'b0;
      ext_sel   = 1'b0;
      zero_fill = 1'b0;
      case (memory_mode_select)
         psmrs_pkg::MODE_INTERNAL_ONLY:
         begin
            int_sel   = in_flash;
            zero_fill = !in_flash;
         end
         psmrs_pkg::MODE_EXTERNAL_ONLY:
            ext_sel = 1'b1;
         psmrs_pkg::MODE_BOOT_BLOCK:
         begin
            int_sel = in_boot;
            ext_sel = !in_boot;
         end
         default:
         begin
            int_sel = in_flash;
            ext_sel = !in_flash;
         end
      endcase
   end
endmodule // psmrs_addr_map
`default_nettype wire

// ### rtl/psmrs_pkg.sv
`default_nettype none
package psmrs_pkg;
   localparam int          PC_W           = 21;
   localparam int          SP_W           = 5;
   localparam logic [4:0]  STACK_DEPTH    = 5'h1F;
   localparam logic [4:0]  SP_RESET       = 5'h00;
   localparam logic [20:0] RESET_VECTOR   = 21'h000000;
   localparam logic [20:0] HI_IRQ_VECTOR  = 21'h000008;
   localparam logic [20:0] LO_IRQ_VECTOR  = 21'h000018;
   localparam logic [20:0] BOOT_TOP       = 21'h0007FF;
   localparam logic [20:0] FLASH_TOP_48K  = 21'h00BFFF;
   localparam logic [20:0] FLASH_TOP_64K  = 21'h00FFFF;
   localparam logic [1:0]  MODE_INTERNAL_ONLY = 2'h3;
   localparam logic [1:0]  MODE_EXTERNAL_ONLY = 2'h2;
   localparam logic [1:0]  MODE_BOOT_BLOCK    = 2'h1;
   localparam logic [1:0]  MODE_EXTENDED      = 2'h0;
   localparam logic [11:0] REG_CONFIG     = 12'h000;
   localparam logic [11:0] REG_STACK_IDX  = 12'h004;
   localparam logic [11:0] REG_TOP_UPPER  = 12'h008;
   localparam logic [11:0] REG_TOP_HIGH   = 12'h00C;
   localparam logic [11:0] REG_TOP_LOW    = 12'h010;
   localparam logic [11:0] REG_MEM_CTRL   = 12'h014;
   localparam int          CFG_WAIT_BIT   = 7;
   localparam logic [7:0]  CFG_USED_MASK  = 8'h83;
   localparam int          IDX_FULL_BIT   = 7;
   localparam int          IDX_UNF_BIT    = 6;
   localparam int          MEMCTL_WAIT_LSB = 4;
   localparam logic [7:0]  MEMCTL_RESET   = 8'h00;
   typedef enum logic [1:0] {ACC_EXEC, ACC_TABLE_READ, ACC_TABLE_WRITE} psmrs_access_t;
   typedef enum logic [2:0] {SEL_NONE, SEL_CONFIG, SEL_IDX, SEL_UPPER, SEL_HIGH, SEL_LOW, SEL_MEMCTL} psmrs_regsel_t;
   typedef struct packed {
      logic        push;
      logic        pop;
      logic        irq_ack;
      logic        irq_high;
      logic [20:0] pc;
   } psmrs_seq_t;
   typedef struct packed {
      logic        valid;
      logic        vector;
      logic [20:0] pc;
   } psmrs_ret_t;
endpackage
`default_nettype wire

// ### rtl/psmrs_stack_ram.sv
`default_nettype none
module psmrs_stack_ram (
   input  wire logic        clk,
   input  wire logic        ce,
   input  wire logic        we,
   input  wire logic [4:0]  waddr,
   input  wire logic [20:0] wdata,
   input  wire logic [4:0]  raddr,
   output logic [20:0]      rdata
);
   // Entries 1..31 only; index zero has no storage
   logic [20:0] mem [1:31];

   always_ff @(posedge clk)
   begin
      if (ce && we && waddr != 5'h00)
         mem[waddr] <= wdata;
   end

   assign rdata = (raddr == 5'h00) ? 21'h000000 : mem[raddr];
endmodule // psmrs_stack_ram
`default_nettype wire

// ### rtl/psmrs_top.sv
// Chosen here: the register addresses and the APB register port.
`default_nettype none
module psmrs_top (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  power_on,
   input  wire logic [7:0]            memory_mode_config_byte,
   input  wire logic                  flash_64k,
   input  wire logic                  stack_fault_reset_enable,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire psmrs_pkg::psmrs_seq_t seq_req,
   output psmrs_pkg::psmrs_ret_t      seq_ret,
   output logic                       stack_fault_reset,
   output logic [20:0]                reset_vector,
   input  wire logic [20:0]           fetch_addr,
   input  wire logic                  fetch_valid,
   input  wire psmrs_pkg::psmrs_access_t fetch_kind,
   input  wire logic [15:0]           flash_rdata,
   input  wire logic [15:0]           ext_rdata,
   output logic                       flash_rd_en,
   output logic                       flash_wr_en,
   output logic                       ext_rd_en,
   output logic                       ext_wr_en,
   output logic [15:0]                fetch_rdata,
   output logic [1:0]                 ext_wait_states
);
   logic [7:0]            cfg;
   logic                  fl64;
   logic                  fault_en;
   logic [7:0]            next_cfg;
   logic                  next_fl64;
   logic                  next_fault_en;
   logic [9:0]            pin_s1;
   logic [9:0]            pin_s2;
   logic [9:0]            pin_s3;
   logic [9:0]            pin_q;
   logic [9:0]            next_pin_q;
   logic [4:0]            sp;
   logic [4:0]            next_sp;
   logic                  full;
   logic                  next_full;
   logic                  unf;
   logic                  next_unf;
   logic [7:0]            memory_control_reg;
   logic [7:0]            next_memory_control_reg;
   logic [31:0]           next_prdata;
   psmrs_pkg::psmrs_ret_t next_seq_ret;
   logic                  next_fault;
   logic [15:0]           next_fetch_rdata;
   logic                  ram_we;
   logic [4:0]            ram_waddr;
   logic [20:0]           ram_wdata;
   logic [20:0]           top_entry;
   logic                  int_sel;
   logic                  ext_sel;
   logic                  zero_fill;
   logic                  apb_write;
   psmrs_pkg::psmrs_regsel_t wr_sel;
   psmrs_pkg::psmrs_regsel_t rd_sel;

   function automatic psmrs_pkg::psmrs_regsel_t reg_decode(input logic [11:0] a);
      psmrs_pkg::psmrs_regsel_t s;
      if (a == psmrs_pkg::REG_CONFIG)
         s = psmrs_pkg::SEL_CONFIG;
      else if (a == psmrs_pkg::REG_STACK_IDX)
         s = psmrs_pkg::SEL_IDX;
      else if (a == psmrs_pkg::REG_TOP_UPPER)
         s = psmrs_pkg::SEL_UPPER;
      else if (a == psmrs_pkg::REG_TOP_HIGH)
         s = psmrs_pkg::SEL_HIGH;
      else if (a == psmrs_pkg::REG_TOP_LOW)
         s = psmrs_pkg::SEL_LOW;
      else if (a == psmrs_pkg::REG_MEM_CTRL)
         s = psmrs_pkg::SEL_MEMCTL;
      else
         s = psmrs_pkg::SEL_NONE;
      return s;
   endfunction

   psmrs_stack_ram u_ram (
      .clk   (clk),
      .ce    (ce),
      .we    (ram_we),
      .waddr (ram_waddr),
      .wdata (ram_wdata),
      .raddr (sp),
      .rdata (top_entry)
   );

   psmrs_addr_map u_map (
      .addr               (fetch_addr),
      .memory_mode_select (cfg[1:0]),
      .flash_64k          (fl64),
      .int_sel            (int_sel),
      .ext_sel            (ext_sel),
      .zero_fill          (zero_fill)
   );

   // Pins from outside: a change counts once stages two and three agree
   always_comb
   begin
      next_pin_q = (pin_s2 & pin_s3) | (pin_q & (pin_s2 ^ pin_s3));
   end

   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         pin_s1 <= {stack_fault_reset_enable, flash_64k, memory_mode_config_byte};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_q  <= next_pin_q;
      end
   end

   // Configuration taken only while reset is held
   always_comb
   begin
      next_cfg      = cfg;
      next_fl64     = fl64;
      next_fault_en = fault_en;
      if (rst)
      begin
         next_cfg      = pin_q[7:0] & psmrs_pkg::CFG_USED_MASK;
         next_fl64     = pin_q[8];
         next_fault_en = pin_q[9];
      end
   end

   always_ff @(posedge clk)
   begin
      cfg      <= next_cfg;
      fl64     <= next_fl64;
      fault_en <= next_fault_en;
   end

   // Fetch and table strobes
   assign flash_rd_en = fetch_valid && int_sel && fetch_kind != psmrs_pkg::ACC_TABLE_WRITE;
   assign flash_wr_en = fetch_valid && int_sel && fetch_kind == psmrs_pkg::ACC_TABLE_WRITE;
   assign ext_rd_en   = fetch_valid && ext_sel && fetch_kind != psmrs_pkg::ACC_TABLE_WRITE;
   assign ext_wr_en   = fetch_valid && ext_sel && fetch_kind == psmrs_pkg::ACC_TABLE_WRITE;
   assign reset_vector = psmrs_pkg::RESET_VECTOR;

   always_comb
   begin
      if (zero_fill || !(int_sel || ext_sel))
         next_fetch_rdata = 16'h0000;
      else if (int_sel)
         next_fetch_rdata = flash_rdata;
      else
         next_fetch_rdata = ext_rdata;
   end

   assign ext_wait_states = cfg[psmrs_pkg::CFG_WAIT_BIT] ? 2'h0 :
                            memory_control_reg[psmrs_pkg::MEMCTL_WAIT_LSB +: 2];

   // APB slave: zero wait states, read data captured in setup
   assign pready    = 1'b1;
   assign apb_write = psel && penable && pwrite;
   assign wr_sel    = reg_decode(paddr);
   assign rd_sel    = reg_decode(paddr);
   assign pslverr   = psel && penable && (wr_sel == psmrs_pkg::SEL_NONE);

   always_comb
   begin
      next_prdata = prdata;
      if (psel && !penable && !pwrite)
      begin
         next_prdata = 32'h00000000;
         case (rd_sel)
            psmrs_pkg::SEL_CONFIG:
               next_prdata[7:0] = cfg & psmrs_pkg::CFG_USED_MASK;
            psmrs_pkg::SEL_IDX:
               next_prdata[7:0] = {full, unf, 1'b0, sp};
            psmrs_pkg::SEL_UPPER:
               next_prdata[7:0] = {3'h0, top_entry[20:16]};
            psmrs_pkg::SEL_HIGH:
               next_prdata[7:0] = top_entry[15:8];
            psmrs_pkg::SEL_LOW:
               next_prdata[7:0] = top_entry[7:0];
            psmrs_pkg::SEL_MEMCTL:
               next_prdata[7:0] = memory_control_reg;
            default:
               next_prdata = 32'h00000000;
         endcase
      end
   end

   // Return stack and software access
   always_comb
   begin
      next_sp                 = sp;
      next_full               = full;
      next_unf                = unf;
      next_memory_control_reg = memory_control_reg;
      next_seq_ret            = '0;
      next_fault              = 1'b0;
      ram_we                  = 1'b0;
      ram_waddr               = sp;
      ram_wdata               = seq_req.pc;
      if (seq_req.push || seq_req.irq_ack)
      begin
         if (seq_req.irq_ack)
         begin
            next_seq_ret.valid  = 1'b1;
            next_seq_ret.vector = 1'b1;
            next_seq_ret.pc     = seq_req.irq_high ? psmrs_pkg::HI_IRQ_VECTOR :
                                  psmrs_pkg::LO_IRQ_VECTOR;
         end
         if (sp == psmrs_pkg::STACK_DEPTH)
         begin
            next_full  = 1'b1;
            next_fault = fault_en;
            if (fault_en)
               next_sp = psmrs_pkg::SP_RESET;
         end
         else
         begin
            next_sp   = sp + 5'h01;
            ram_we    = 1'b1;
            ram_waddr = sp + 5'h01;
            if (sp + 5'h01 == psmrs_pkg::STACK_DEPTH)
            begin
               next_full = 1'b1;
               if (fault_en)
               begin
                  next_fault = 1'b1;
                  next_sp    = psmrs_pkg::SP_RESET;
               end
            end
         end
      end
      else if (seq_req.pop)
      begin
         next_seq_ret.valid = 1'b1;
         if (sp == psmrs_pkg::SP_RESET)
         begin
            next_seq_ret.pc = psmrs_pkg::RESET_VECTOR;
            next_unf        = 1'b1;
            next_fault      = fault_en;
         end
         else
         begin
            next_seq_ret.pc = top_entry;
            next_sp         = sp - 5'h01;
         end
      end
      else if (apb_write)
      begin
         case (wr_sel)
            psmrs_pkg::SEL_IDX:
            begin
               next_sp = pwdata[4:0];
               if (!pwdata[psmrs_pkg::IDX_FULL_BIT])
                  next_full = 1'b0;
               if (!pwdata[psmrs_pkg::IDX_UNF_BIT])
                  next_unf = 1'b0;
            end
            psmrs_pkg::SEL_UPPER:
            begin
               ram_we    = 1'b1;
               ram_wdata = {pwdata[4:0], top_entry[15:0]};
            end
            psmrs_pkg::SEL_HIGH:
            begin
               ram_we    = 1'b1;
               ram_wdata = {top_entry[20:16], pwdata[7:0], top_entry[7:0]};
            end
            psmrs_pkg::SEL_LOW:
            begin
               ram_we    = 1'b1;
               ram_wdata = {top_entry[20:8], pwdata[7:0]};
            end
            psmrs_pkg::SEL_MEMCTL:
               next_memory_control_reg = pwdata[7:0];
            default:
               next_memory_control_reg = memory_control_reg;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sp                 <= psmrs_pkg::SP_RESET;
         memory_control_reg <= psmrs_pkg::MEMCTL_RESET;
         prdata             <= 32'h00000000;
         seq_ret            <= '0;
         stack_fault_reset  <= 1'b0;
         fetch_rdata        <= 16'h0000;
         if (power_on)
         begin
            full <= 1'b0;
            unf  <= 1'b0;
         end
      end
      else if (ce)
      begin
         sp                 <= next_sp;
         full               <= next_full;
         unf                <= next_unf;
         memory_control_reg <= next_memory_control_reg;
         prdata             <= next_prdata;
         seq_ret            <= next_seq_ret;
         stack_fault_reset  <= next_fault;
         fetch_rdata        <= next_fetch_rdata;
      end
   end
endmodule // psmrs_top
`default_nettype wire

// ### tb/psmrs_far_model.sv
`default_nettype none
module psmrs_far_model (
   input  wire logic [20:0] fetch_addr,
   input  wire logic        flash_rd_en,
   input  wire logic        ext_rd_en,
   output logic [15:0]      flash_rdata,
   output logic [15:0]      ext_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Unselected memories show the inverted word, never a stale one
   assign flash_rdata = flash_rd_en ? fetch_addr[15:0] ^ 16'h0F0F : ~(fetch_addr[15:0] ^ 16'h0F0F);
   assign ext_rdata   = ext_rd_en ? fetch_addr[20:5] ^ 16'h3C3C : ~(fetch_addr[20:5] ^ 16'h3C3C);
endmodule // psmrs_far_model
`default_nettype wire

// ### tb/psmrs_properties.sv
`default_nettype none
module psmrs_checker (
   input wire logic                     clk,
   input wire logic                     rst,
   input wire logic                     ce,
   input wire logic [7:0]               memory_mode_config_byte,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic [11:0]              paddr,
   input wire logic                     pslverr,
   input wire psmrs_pkg::psmrs_seq_t    seq_req,
   input wire psmrs_pkg::psmrs_ret_t    seq_ret,
   input wire logic [20:0]              reset_vector,
   input wire logic                     fetch_valid,
   input wire psmrs_pkg::psmrs_access_t fetch_kind,
   input wire logic                     flash_rd_en,
   input wire logic                     flash_wr_en,
   input wire logic                     ext_rd_en,
   input wire logic                     ext_wr_en,
   input wire logic [15:0]              fetch_rdata,
   input wire logic [1:0]               ext_wait_states
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cfg_q;
   logic [7:0] next_cfg_q;
   logic       any_strobe;
   assign any_strobe = flash_rd_en || flash_wr_en || ext_rd_en || ext_wr_en;
   // Copy of the configuration latched at reset
   always_comb next_cfg_q = rst ? memory_mode_config_byte : cfg_q;
   always_ff @(posedge clk) cfg_q <= next_cfg_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_pop;
      ce && seq_req.pop && !seq_req.push && !seq_req.irq_ack;
   endsequence
   sequence s_irq(hi);
      ce && seq_req.irq_ack && !seq_req.push && seq_req.irq_high == hi;
   endsequence
   a_pop_answer: assert property (s_pop |=> seq_ret.valid && !seq_ret.vector)
      else $error("pop not answered");
   a_hi_vector: assert property (s_irq(1'b1) |=> seq_ret.valid && seq_ret.pc == psmrs_pkg::HI_IRQ_VECTOR)
      else $error("wrong high vector");
   a_lo_vector: assert property (s_irq(1'b0) |=> seq_ret.valid && seq_ret.pc == psmrs_pkg::LO_IRQ_VECTOR)
      else $error("wrong low vector");
   a_ret_cause: assert property (seq_ret.valid |-> $past(seq_req.pop || seq_req.irq_ack))
      else $error("return without request");
   a_reset_vec: assert property (reset_vector == psmrs_pkg::RESET_VECTOR)
      else $error("reset vector wrong");
   a_unmapped_err: assert property (psel && penable && paddr > psmrs_pkg::REG_MEM_CTRL |-> pslverr)
      else $error("unmapped access not refused");
   a_zero_fill: assert property (ce && fetch_valid && !any_strobe |=> fetch_rdata == 16'h0000)
      else $error("unmapped fetch not zero");
   a_int_only: assert property (cfg_q[1:0] == psmrs_pkg::MODE_INTERNAL_ONLY |-> !(ext_rd_en || ext_wr_en))
      else $error("external access in internal mode");
   a_ext_only: assert property (cfg_q[1:0] == psmrs_pkg::MODE_EXTERNAL_ONLY |-> !(flash_rd_en || flash_wr_en))
      else $error("flash access in external mode");
   a_wait_off: assert property (cfg_q[7] |-> ext_wait_states == 2'h0)
      else $error("wait states not disabled");
   a_write_kind: assert property (flash_wr_en || ext_wr_en |-> fetch_kind == psmrs_pkg::ACC_TABLE_WRITE)
      else $error("write strobe on read");
   a_one_target: assert property (!((flash_rd_en || flash_wr_en) && (ext_rd_en || ext_wr_en)))
      else $error("two targets at once");
endmodule // psmrs_checker
bind psmrs_top psmrs_checker i_checker (.*);
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, power_on = 1'b1, flash_64k = 1'b0, stack_fault_reset_enable = 1'b0;
   logic [7:0]  memory_mode_config_byte = 8'hFF;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, stack_fault_reset;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        flash_rd_en, flash_wr_en, ext_rd_en, ext_wr_en, fetch_valid = 1'b0, fv_d = 1'b0, full, unf;
   logic [20:0] reset_vector, fetch_addr = 21'h0, v;
   logic [15:0] flash_rdata, ext_rdata, fetch_rdata;
   logic [1:0]  ext_wait_states;
   psmrs_pkg::psmrs_seq_t    seq_req = '0;
   psmrs_pkg::psmrs_ret_t    seq_ret;
   psmrs_pkg::psmrs_access_t fetch_kind = psmrs_pkg::ACC_EXEC;
   logic [31:0] q_reg[$];
   logic [20:0] q_ret[$];
   logic [15:0] q_fetch[$];
   logic [20:0] stk[32];
   logic [20:0] addrs[5] = '{21'h000100, 21'h000900, 21'h00C002, 21'h010000, 21'h1FFFFE};
   int sp, failures, compares, faults;
   psmrs_top i_dut (.*);
   psmrs_far_model i_far (.*);
   always #2 clk = ~clk;
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   always @(posedge clk)
   begin
      if (psel && penable && !pwrite && q_reg.size() > 0) cmp("register", q_reg.pop_front(), prdata);
      if (seq_ret.valid === 1'b1) cmp("return pc", q_ret.pop_front(), 32'(seq_ret.pc));
      if (fv_d) cmp("fetch data", 32'(q_fetch.pop_front()), 32'(fetch_rdata));
      if (stack_fault_reset === 1'b1) faults++;
      fv_d = fetch_valid && !rst;
   end
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      q_reg.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   function automatic logic [31:0] idx_val();
      return {24'h0, full, unf, 1'b0, 5'(sp)};
   endfunction
   // kind 0 push, 1 pop, 2 interrupt acknowledge
   task automatic op(input int kind, input logic [20:0] pc, input logic hi);
      seq_req <= '{push: kind == 0, pop: kind == 1, irq_ack: kind == 2, irq_high: hi, pc: pc};
      if (kind != 1)
      begin
         if (sp < 31)
         begin
            sp++;
            stk[sp] = pc;
         end
         if (sp == 31) full = 1'b1;
         if (sp == 31 && stack_fault_reset_enable) sp = 0;
         if (kind == 2) q_ret.push_back(hi ? 21'h000008 : 21'h000018);
      end
      else if (sp == 0)
      begin
         unf = 1'b1;
         q_ret.push_back(21'h0);
      end
      else
      begin
         q_ret.push_back(stk[sp]);
         sp--;
      end
      @(posedge clk);
   endtask
   task automatic top3();
      for (int j = 0; j < 3; j++) rd(12'h008 + 12'(4 * j), 32'((stk[sp] >> (16 - 8 * j)) & 21'hFF));
   endtask
   task automatic do_reset(input logic [7:0] c, input logic po);
      memory_mode_config_byte <= c;
      power_on <= po;
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      sp = 0;
      if (po)
      begin
         full = 1'b0;
         unf = 1'b0;
      end
   endtask
   task automatic fetch(input logic [20:0] a);
      logic [1:0] m;
      logic in_f;
      logic [15:0] d;
      psmrs_pkg::psmrs_access_t k;
      m = memory_mode_config_byte[1:0];
      in_f = a <= (flash_64k ? 21'h00FFFF : 21'h00BFFF) && m != 2'h2 && (m != 2'h1 || a <= 21'h0007FF);
      k = psmrs_pkg::psmrs_access_t'($urandom_range(2));
      d = in_f ? a[15:0] ^ 16'h0F0F : m != 2'h3 ? a[20:5] ^ 16'h3C3C : 16'h0000;
      // Table write leaves the read bus deselected: inverse word
      if (k == psmrs_pkg::ACC_TABLE_WRITE && (in_f || m != 2'h3)) d = ~d;
      fetch_addr <= a;
      fetch_valid <= 1'b1;
      fetch_kind <= k;
      q_fetch.push_back(d);
      @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #80000;
      failures++;
      print_verdict();
   end
   initial
   begin
      void'($urandom(28429));
      do_reset(8'hFF, 1'b1);
      rd(12'h000, 32'h83);
      rd(12'h004, idx_val());
      rd(12'h020, 32'h0);
      for (int i = 0; i < 32; i++) op(0, 21'($urandom), 1'b0);
      seq_req <= '0;
      rd(12'h004, idx_val());
      top3();
      for (int i = 0; i < 32; i++) op(1, 21'h0, 1'b0);
      seq_req <= '0;
      rd(12'h004, idx_val());
      do_reset(8'hFF, 1'b0);
      rd(12'h004, idx_val());
      apb(1'b1, 12'h004, 32'h03);
      sp = 3;
      full = 1'b0;
      unf = 1'b0;
      rd(12'h004, idx_val());
      // Push while frozen must leave the index alone
      ce <= 1'b0;
      seq_req <= '{push: 1'b1, pop: 1'b0, irq_ack: 1'b0, irq_high: 1'b0, pc: 21'h0};
      @(posedge clk);
      ce <= 1'b1;
      seq_req <= '0;
      rd(12'h004, idx_val());
      v = 21'($urandom);
      // No stack traffic while the top entry is edited
      for (int j = 0; j < 3; j++) apb(1'b1, 12'h008 + 12'(4 * j), 32'((v >> (16 - 8 * j)) & 21'hFF));
      stk[3] = v;
      top3();
      op(2, 21'($urandom), 1'b1);
      op(2, 21'($urandom), 1'b0);
      for (int i = 0; i < 3; i++) op(1, 21'h0, 1'b0);
      seq_req <= '0;
      for (int m = 0; m < 4; m++)
      begin
         flash_64k <= 1'($urandom);
         do_reset({1'($urandom), 5'h00, 2'(m)}, 1'b1);
         rd(12'h000, 32'(memory_mode_config_byte));
         apb(1'b1, 12'h014, 32'h20);
         #1 cmp("wait states", memory_mode_config_byte[7] ? 32'h0 : 32'h2, 32'(ext_wait_states));
         @(posedge clk);
         foreach (addrs[k]) fetch(addrs[k]);
         fetch_valid <= 1'b0;
      end
      stack_fault_reset_enable <= 1'b1;
      do_reset(8'hFF, 1'b1);
      for (int i = 0; i < 31; i++) op(0, 21'($urandom), 1'b0);
      seq_req <= '0;
      rd(12'h004, idx_val());
      repeat (3) @(posedge clk);
      cmp("fault pulses", 32'h1, 32'(faults));
      print_verdict();
   end
endmodule // tb
`default_nettype wire
